// File: shared/lcd_gpio_defs.svh
// offsets, field positions, reset values and codes of the shared lcd gpio ports
`ifndef LCD_GPIO_DEFS_SVH
`define LCD_GPIO_DEFS_SVH

// register indexes; byte address is four times the index
`define IDX_PORT_A_DATA_LATCH 16'hFFDA
`define IDX_PORT_B_DATA_LATCH 16'hFFDB
`define IDX_PORT_A_DIRECTION 16'hFFEA
`define IDX_PORT_B_DIRECTION 16'hFFEB
`define IDX_LCD_PORT_CONTROL 16'hFFD0
`define IDX_POWER_MODE 16'hFFD1

// address split of a 32-bit byte address
`define ADDR_IDX_LSB 2
`define ADDR_IDX_MSB 17

// field positions
`define SEGSEL_LSB 0
`define SEGSEL_MSB 3
`define PWR_LSB 0
`define PWR_MSB 2

// reset values
`define RST_DATA_LATCH 8'h00
`define RST_DIRECTION 8'h00
`define RST_SEGSEL 4'h0
`define RST_PWR 3'h0

// direction register read-back value
`define DIRECTION_READ 8'hFF

// power mode codes
`define PWR_ACTIVE 3'h0
`define PWR_SUBACTIVE 3'h1
`define PWR_SLEEP 3'h2
`define PWR_SUBSLEEP 3'h3
`define PWR_WATCH 3'h4
`define PWR_STANDBY 3'h5

// bus response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: shared/lcd_gpio_pkg.sv
// types shared by the lcd gpio port design
package lcd_gpio_pkg;

	// what a port pin does in the present power mode
	typedef enum logic [1:0] {PIN_RUN, PIN_HOLD, PIN_FLOAT} pin_mode_t;

	// software settings of one port
	typedef struct packed {
		logic [7:0] latch;
		logic [7:0] dir;
	} port_cfg_t;

	// what one port drives at its pins
	typedef struct packed {
		logic [7:0] value;
		logic [7:0] enable;
	} pin_drive_t;

endpackage

// File: design/lcd_gpio_pin_sync.sv
// three-stage input synchroniser with agreement filter for port pins
`timescale 1ns/100ps
module lcd_gpio_pin_sync
#(
	parameter int W = 8
)
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// raw pins and accepted level
	input wire logic [W-1:0] i_pin,
	output logic [W-1:0] o_level
);

	logic [W-1:0] meta_r;
	logic [W-1:0] sync2_r;
	logic [W-1:0] sync3_r;
	logic [W-1:0] level_r;

	// ----------------------------------------
	// synchroniser chain
	// ----------------------------------------
	// first stage feeds only the second stage
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			meta_r <= '0;
			sync2_r <= '0;
			sync3_r <= '0;
		end
		else
		begin
			meta_r <= i_pin;
			sync2_r <= meta_r;
			sync3_r <= sync2_r;
		end
	end

	// a change counts only once stages two and three agree
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			level_r <= '0;
		else
			for (int b = 0; b < W; b++)
				if (sync2_r[b] == sync3_r[b])
					level_r[b] <= sync3_r[b];
	end

	assign o_level = level_r;

endmodule

// File: design/lcd_shared_gpio_ports.sv
// two 8-bit gpio ports sharing pins with lcd segment outputs, axi4-lite slave
`timescale 1ns/100ps
`include "lcd_gpio_defs.svh"

// How it works
// - eight-bit data latch per port, reset zero
// - output-direction bits read back the latch
// - input-direction bits read the pin level
// - direction one is output, zero input
// - gpio settings drive only gpio pins; data reads merge latch and pin on every pin
// - direction register write-only, reads all ones
// - direction register resets to all inputs
// - port a upper nibble gpio for 00xx
// - port a lower nibble gpio for 00xx/0100
// - port a float, hold, run by mode
// - port b upper nibble gpio for 000x, lower nibble for 000x/0010
// - port b float, hold, run by mode
module lcd_shared_gpio_ports
	import lcd_gpio_pkg::*;
#(
	parameter int PORT_W = 8
)
(
	// clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_RST,
	// axi4-lite write address channel
	input wire logic [31:0] I_AXI_AWADDR,
	input wire logic [2:0] I_AXI_AWPROT,
	input wire logic I_AXI_AWVALID,
	output logic O_AXI_AWREADY,
	// axi4-lite write data channel
	input wire logic [31:0] I_AXI_WDATA,
	input wire logic [3:0] I_AXI_WSTRB,
	input wire logic I_AXI_WVALID,
	output logic O_AXI_WREADY,
	// axi4-lite write response channel
	output logic [1:0] O_AXI_BRESP,
	output logic O_AXI_BVALID,
	input wire logic I_AXI_BREADY,
	// axi4-lite read address channel
	input wire logic [31:0] I_AXI_ARADDR,
	input wire logic [2:0] I_AXI_ARPROT,
	input wire logic I_AXI_ARVALID,
	output logic O_AXI_ARREADY,
	// axi4-lite read data channel
	output logic [31:0] O_AXI_RDATA,
	output logic [1:0] O_AXI_RRESP,
	output logic O_AXI_RVALID,
	input wire logic I_AXI_RREADY,
	// segment waveforms from the lcd driver logic
	input wire logic [PORT_W-1:0] I_PORT_A_SEG_WAVE,
	input wire logic [PORT_W-1:0] I_PORT_B_SEG_WAVE,
	// port a pins
	input wire logic [PORT_W-1:0] I_PORT_A_PIN,
	output logic [PORT_W-1:0] O_PORT_A_PIN,
	output logic [PORT_W-1:0] O_PORT_A_PIN_OE,
	// port b pins
	input wire logic [PORT_W-1:0] I_PORT_B_PIN,
	output logic [PORT_W-1:0] O_PORT_B_PIN,
	output logic [PORT_W-1:0] O_PORT_B_PIN_OE
);

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	// the nibble-wise segment decode is built for exactly eight pins
	if (PORT_W != 8)
	begin : g_bad_width
		$error("lcd_shared_gpio_ports: PORT_W must be 8");
	end

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	port_cfg_t port_a_r;
	port_cfg_t port_b_r;
	logic [3:0] segment_select_field_r;
	logic [2:0] power_mode_r;
	pin_mode_t pin_mode_a;
	pin_mode_t pin_mode_b;
	logic [7:0] gpio_mask_a;
	logic [7:0] gpio_mask_b;
	pin_drive_t drive_a_nxt;
	pin_drive_t drive_b_nxt;
	pin_drive_t drive_a_r;
	pin_drive_t drive_b_r;
	logic [7:0] level_a;
	logic [7:0] level_b;
	logic [7:0] read_a;
	logic [7:0] read_b;

	logic aw_held_r;
	logic [31:0] aw_addr_r;
	logic w_held_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;

	logic wr_fire;
	logic wr_lane0;
	logic [15:0] wr_idx;
	logic wr_upper_ok;
	logic wr_hit_a_latch;
	logic wr_hit_b_latch;
	logic wr_hit_a_dir;
	logic wr_hit_b_dir;
	logic wr_hit_ctrl;
	logic wr_hit_pwr;
	logic wr_mapped;
	logic rd_fire;
	logic [15:0] rd_idx;
	logic rd_upper_ok;
	logic [31:0] rd_data_nxt;
	logic rd_mapped_nxt;

	// ----------------------------------------
	// segment-select decode
	// ----------------------------------------
	// port a: upper nibble gpio for 00xx, lower for 00xx or 0100
	function automatic logic [7:0] gpio_mask_port_a(input logic [3:0] sel);
		logic hi;
		logic lo;
		hi = (sel[3:2] == 2'b00);
		lo = (sel[3:2] == 2'b00) || (sel == 4'b0100);
		return {{4{hi}}, {4{lo}}};
	endfunction

	// port b: upper nibble gpio for 000x, lower for 000x or 0010
	function automatic logic [7:0] gpio_mask_port_b(input logic [3:0] sel);
		logic hi;
		logic lo;
		hi = (sel[3:1] == 3'b000);
		lo = (sel[3:1] == 3'b000) || (sel == 4'b0010);
		return {{4{hi}}, {4{lo}}};
	endfunction

	assign gpio_mask_a = gpio_mask_port_a(segment_select_field_r);
	assign gpio_mask_b = gpio_mask_port_b(segment_select_field_r);

	// ----------------------------------------
	// power mode decode
	// ----------------------------------------
	// both ports float in standby and freeze in the sleep-type modes;
	// an unknown code is treated as running so the pins never lock up
	always_comb
	begin
		pin_mode_a = PIN_RUN;
		pin_mode_b = PIN_RUN;
		case (power_mode_r)
			`PWR_ACTIVE, `PWR_SUBACTIVE:
			begin
				pin_mode_a = PIN_RUN;
				pin_mode_b = PIN_RUN;
			end
			`PWR_SLEEP, `PWR_SUBSLEEP, `PWR_WATCH:
			begin
				pin_mode_a = PIN_HOLD;
				pin_mode_b = PIN_HOLD;
			end
			`PWR_STANDBY:
			begin
				pin_mode_a = PIN_FLOAT;
				pin_mode_b = PIN_FLOAT;
			end
			default:
			begin
				pin_mode_a = PIN_RUN;
				pin_mode_b = PIN_RUN;
			end
		endcase
	end

	// ----------------------------------------
	// pin drive selection
	// ----------------------------------------
	// gpio pins follow latch and direction; segment pins always drive
	// the waveform, so latch and direction have no say there
	always_comb
	begin
		for (int b = 0; b < 8; b++)
		begin
			if (gpio_mask_a[b])
			begin
				drive_a_nxt.value[b] = port_a_r.latch[b];
				drive_a_nxt.enable[b] = port_a_r.dir[b];
			end
			else
			begin
				drive_a_nxt.value[b] = I_PORT_A_SEG_WAVE[b];
				drive_a_nxt.enable[b] = 1'b1;
			end
			if (gpio_mask_b[b])
			begin
				drive_b_nxt.value[b] = port_b_r.latch[b];
				drive_b_nxt.enable[b] = port_b_r.dir[b];
			end
			else
			begin
				drive_b_nxt.value[b] = I_PORT_B_SEG_WAVE[b];
				drive_b_nxt.enable[b] = 1'b1;
			end
		end
	end

	// ----------------------------------------
	// pin output registers
	// ----------------------------------------
	// reset floats the pins; hold keeps the last driven state
	always_ff @(posedge I_SYS_CLK or posedge I_RST)
	begin
		if (I_RST)
			drive_a_r <= '0;
		else
			unique case (pin_mode_a)
				PIN_RUN: drive_a_r <= drive_a_nxt;
				PIN_HOLD: drive_a_r <= drive_a_r;
				PIN_FLOAT: drive_a_r.enable <= 8'h00;
			endcase
	end

	always_ff @(posedge I_SYS_CLK or posedge I_RST)
	begin
		if (I_RST)
			drive_b_r <= '0;
		else
			unique case (pin_mode_b)
				PIN_RUN: drive_b_r <= drive_b_nxt;
				PIN_HOLD: drive_b_r <= drive_b_r;
				PIN_FLOAT: drive_b_r.enable <= 8'h00;
			endcase
	end

	assign O_PORT_A_PIN = drive_a_r.value;
	assign O_PORT_A_PIN_OE = drive_a_r.enable;
	assign O_PORT_B_PIN = drive_b_r.value;
	assign O_PORT_B_PIN_OE = drive_b_r.enable;

	// ----------------------------------------
	// pin input synchronisers
	// ----------------------------------------
	lcd_gpio_pin_sync #(.W(8)) u_sync_a
	(
		.i_clk(I_SYS_CLK),
		.i_rst(I_RST),
		.i_pin(I_PORT_A_PIN),
		.o_level(level_a)
	);

	lcd_gpio_pin_sync #(.W(8)) u_sync_b
	(
		.i_clk(I_SYS_CLK),
		.i_rst(I_RST),
		.i_pin(I_PORT_B_PIN),
		.o_level(level_b)
	);

	// data read merges latch and pin per direction bit, for segment pins too
	assign read_a = (port_a_r.dir & port_a_r.latch) | (~port_a_r.dir & level_a);
	assign read_b = (port_b_r.dir & port_b_r.latch) | (~port_b_r.dir & level_b);

	// ----------------------------------------
	// bus write path
	// ----------------------------------------
	// address and data are caught separately; no new item is taken
	// while a response waits, which keeps one write in flight
	assign O_AXI_AWREADY = !aw_held_r && !bvalid_r;
	assign O_AXI_WREADY = !w_held_r && !bvalid_r;

	always_ff @(posedge I_SYS_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			aw_held_r <= 1'b0;
			aw_addr_r <= 32'h0000_0000;
		end
		else if (I_AXI_AWVALID && O_AXI_AWREADY)
		begin
			aw_held_r <= 1'b1;
			aw_addr_r <= I_AXI_AWADDR;
		end
		else if (wr_fire)
			aw_held_r <= 1'b0;
	end

	always_ff @(posedge I_SYS_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			w_held_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end
		else if (I_AXI_WVALID && O_AXI_WREADY)
		begin
			w_held_r <= 1'b1;
			w_data_r <= I_AXI_WDATA;
			w_strb_r <= I_AXI_WSTRB;
		end
		else if (wr_fire)
			w_held_r <= 1'b0;
	end

	// write decode; only byte lane zero carries register bits
	assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
	assign wr_lane0 = w_strb_r[0];
	assign wr_idx = aw_addr_r[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
	assign wr_upper_ok = (aw_addr_r[31:`ADDR_IDX_MSB+1] == '0) && (aw_addr_r[1:0] == 2'b00);
	assign wr_hit_a_latch = wr_upper_ok && (wr_idx == `IDX_PORT_A_DATA_LATCH);
	assign wr_hit_b_latch = wr_upper_ok && (wr_idx == `IDX_PORT_B_DATA_LATCH);
	assign wr_hit_a_dir = wr_upper_ok && (wr_idx == `IDX_PORT_A_DIRECTION);
	assign wr_hit_b_dir = wr_upper_ok && (wr_idx == `IDX_PORT_B_DIRECTION);
	assign wr_hit_ctrl = wr_upper_ok && (wr_idx == `IDX_LCD_PORT_CONTROL);
	assign wr_hit_pwr = wr_upper_ok && (wr_idx == `IDX_POWER_MODE);
	assign wr_mapped = wr_hit_a_latch || wr_hit_b_latch || wr_hit_a_dir || wr_hit_b_dir
		|| wr_hit_ctrl || wr_hit_pwr;

	// response stands until the master takes it
	always_ff @(posedge I_SYS_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (I_AXI_BREADY)
			bvalid_r <= 1'b0;
	end

	assign O_AXI_BVALID = bvalid_r;
	assign O_AXI_BRESP = bresp_r;

	// ----------------------------------------
	// port registers
	// ----------------------------------------
	// latch and direction of both ports, cleared by reset
	always_ff @(posedge I_SYS_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			port_a_r.latch <= `RST_DATA_LATCH;
			port_b_r.latch <= `RST_DATA_LATCH;
			port_a_r.dir <= `RST_DIRECTION;
			port_b_r.dir <= `RST_DIRECTION;
		end
		else if (wr_fire && wr_lane0)
		begin
			if (wr_hit_a_latch)
				port_a_r.latch <= w_data_r[7:0];
			if (wr_hit_b_latch)
				port_b_r.latch <= w_data_r[7:0];
			if (wr_hit_a_dir)
				port_a_r.dir <= w_data_r[7:0];
			if (wr_hit_b_dir)
				port_b_r.dir <= w_data_r[7:0];
		end
	end

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	// segment select and power mode steer the pin muxes above
	always_ff @(posedge I_SYS_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			segment_select_field_r <= `RST_SEGSEL;
			power_mode_r <= `RST_PWR;
		end
		else if (wr_fire && wr_lane0)
		begin
			if (wr_hit_ctrl)
				segment_select_field_r <= w_data_r[`SEGSEL_MSB:`SEGSEL_LSB];
			if (wr_hit_pwr)
				power_mode_r <= w_data_r[`PWR_MSB:`PWR_LSB];
		end
	end

	// ----------------------------------------
	// bus read path
	// ----------------------------------------
	// one read in flight; the address is taken only while no data waits
	assign O_AXI_ARREADY = !rvalid_r;
	assign rd_fire = I_AXI_ARVALID && !rvalid_r;
	assign rd_idx = I_AXI_ARADDR[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
	assign rd_upper_ok = (I_AXI_ARADDR[31:`ADDR_IDX_MSB+1] == '0) && (I_AXI_ARADDR[1:0] == 2'b00);

	// read mux; narrow registers sit in the low bits, the rest reads zero
	always_comb
	begin
		rd_data_nxt = 32'h0000_0000;
		rd_mapped_nxt = rd_upper_ok;
		case (rd_idx)
			`IDX_PORT_A_DATA_LATCH: rd_data_nxt[7:0] = read_a;
			`IDX_PORT_B_DATA_LATCH: rd_data_nxt[7:0] = read_b;
			`IDX_PORT_A_DIRECTION: rd_data_nxt[7:0] = `DIRECTION_READ;
			`IDX_PORT_B_DIRECTION: rd_data_nxt[7:0] = `DIRECTION_READ;
			`IDX_LCD_PORT_CONTROL: rd_data_nxt[`SEGSEL_MSB:`SEGSEL_LSB] = segment_select_field_r;
			`IDX_POWER_MODE: rd_data_nxt[`PWR_MSB:`PWR_LSB] = power_mode_r;
			default: rd_mapped_nxt = 1'b0;
		endcase
		if (!rd_mapped_nxt)
			rd_data_nxt = 32'h0000_0000;
	end

	// read data stands until the master takes it
	always_ff @(posedge I_SYS_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			rvalid_r <= 1'b0;
			rresp_r <= `RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end
		else if (rd_fire)
		begin
			rvalid_r <= 1'b1;
			rresp_r <= rd_mapped_nxt ? `RESP_OKAY : `RESP_SLVERR;
			rdata_r <= rd_data_nxt;
		end
		else if (I_AXI_RREADY)
			rvalid_r <= 1'b0;
	end

	assign O_AXI_RVALID = rvalid_r;
	assign O_AXI_RRESP = rresp_r;
	assign O_AXI_RDATA = rdata_r;

endmodule

// File: testbench/lcd_gpio_board.sv
// board model that resolves each port pin from the design drive
`timescale 1ns/100ps
module lcd_gpio_board
(
	// design drive and board-side level
	input wire logic [7:0] i_val,
	input wire logic [7:0] i_oe,
	input wire logic [7:0] i_ext,
	// level seen at the pin
	output logic [7:0] o_pin
);
	// no pull-up, so a released pin shows whatever the board puts there
	always_comb
		o_pin = (i_oe & i_val) | (~i_oe & i_ext);
endmodule

// File: testbench/lcd_shared_gpio_ports_properties.sv
// concurrent checks on the bus and pin enables of the shared gpio ports
`timescale 1ns/100ps
`include "lcd_gpio_defs.svh"
module lcd_shared_gpio_ports_properties
#(
	parameter int PORT_W = 8
)
(
	// clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_RST,
	// bus handshakes
	input wire logic I_AXI_AWVALID,
	input wire logic O_AXI_AWREADY,
	input wire logic I_AXI_WVALID,
	input wire logic O_AXI_WREADY,
	input wire logic O_AXI_BVALID,
	input wire logic I_AXI_BREADY,
	input wire logic [31:0] I_AXI_ARADDR,
	input wire logic I_AXI_ARVALID,
	input wire logic O_AXI_ARREADY,
	input wire logic [31:0] O_AXI_RDATA,
	input wire logic [1:0] O_AXI_RRESP,
	input wire logic O_AXI_RVALID,
	input wire logic I_AXI_RREADY,
	// pin enables
	input wire logic [PORT_W-1:0] O_PORT_A_PIN_OE,
	input wire logic [PORT_W-1:0] O_PORT_B_PIN_OE
);
	default clocking @(posedge I_SYS_CLK);
	endclocking
	default disable iff (I_RST);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	wire ar_hit = I_AXI_ARVALID && O_AXI_ARREADY;
	wire w_hit = I_AXI_AWVALID && O_AXI_AWREADY && I_AXI_WVALID && O_AXI_WREADY;
	wire dir_rd = I_AXI_ARADDR[31:2] == {14'h0, `IDX_PORT_A_DIRECTION}
		|| I_AXI_ARADDR[31:2] == {14'h0, `IDX_PORT_B_DIRECTION};
	wire [15:0] oe_all = {O_PORT_A_PIN_OE, O_PORT_B_PIN_OE};
	// direction registers answer all ones one cycle after the address
	AST_DIR_READ: assert property (ar_hit && dir_rd |=> O_AXI_RVALID
		&& O_AXI_RDATA == 32'h000000FF && O_AXI_RRESP == `RESP_OKAY)
		else $error("direction read not all ones");
	// every pin leaves reset as an input
	AST_RST_INPUTS: assert property ($fell(I_RST) |-> oe_all == 16'h0000)
		else $error("pin enabled after reset");
	// enables move only as the result of a completed register write
	AST_OE_BY_WRITE: assert property (!$stable(oe_all) |->
		$past(O_AXI_BVALID) || $past(O_AXI_BVALID, 2))
		else $error("pin enable changed without a write");
	AST_B_DONE: assert property (O_AXI_BVALID && I_AXI_BREADY |=> !O_AXI_BVALID)
		else $error("write response not retired");
	AST_R_DONE: assert property (O_AXI_RVALID && I_AXI_RREADY |=> !O_AXI_RVALID)
		else $error("read response not retired");
	AST_AR_BLOCK: assert property (O_AXI_RVALID |-> !O_AXI_ARREADY)
		else $error("read address taken while answer pending");
	AST_W_BLOCK: assert property (O_AXI_BVALID |-> !O_AXI_AWREADY && !O_AXI_WREADY)
		else $error("write taken while response pending");
	AST_B_AFTER_W: assert property (w_hit |-> ##[1:2] O_AXI_BVALID)
		else $error("write response late");
	COV_WRITE: cover property (w_hit);
	COV_DIR_READ: cover property (ar_hit && dir_rd);
	COV_ALL_OUT: cover property (O_PORT_A_PIN_OE == 8'hFF);
endmodule

bind lcd_shared_gpio_ports lcd_shared_gpio_ports_properties #(.PORT_W(PORT_W)) u_props (
	.I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .I_AXI_AWVALID(I_AXI_AWVALID),
	.O_AXI_AWREADY(O_AXI_AWREADY), .I_AXI_WVALID(I_AXI_WVALID), .O_AXI_WREADY(O_AXI_WREADY),
	.O_AXI_BVALID(O_AXI_BVALID), .I_AXI_BREADY(I_AXI_BREADY), .I_AXI_ARADDR(I_AXI_ARADDR),
	.I_AXI_ARVALID(I_AXI_ARVALID), .O_AXI_ARREADY(O_AXI_ARREADY), .O_AXI_RDATA(O_AXI_RDATA),
	.O_AXI_RRESP(O_AXI_RRESP), .O_AXI_RVALID(O_AXI_RVALID), .I_AXI_RREADY(I_AXI_RREADY),
	.O_PORT_A_PIN_OE(O_PORT_A_PIN_OE), .O_PORT_B_PIN_OE(O_PORT_B_PIN_OE));

// File: testbench/lcd_shared_gpio_ports_tb.sv
// self-checking bench for the shared gpio ports
`timescale 1ns/100ps
`include "lcd_gpio_defs.svh"
module lcd_shared_gpio_ports_tb;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
	logic awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [7:0] ext_a = 8'h5A, ext_b = 8'hC3, seg_a = 8'hA5, seg_b = 8'h3C;
	logic [7:0] pin_a, pin_b, o_a, o_b, oe_a, oe_b;
	int n_fail = 0, total_checks = 0;
	always #5 clk = ~clk;
	lcd_shared_gpio_ports DUT (.I_SYS_CLK(clk), .I_RST(rst),
		.I_AXI_AWADDR(awaddr), .I_AXI_AWPROT(3'h0), .I_AXI_AWVALID(awv),
		.O_AXI_AWREADY(awready), .I_AXI_WDATA(wdata), .I_AXI_WSTRB(4'hF),
		.I_AXI_WVALID(wv), .O_AXI_WREADY(wready), .O_AXI_BRESP(bresp),
		.O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready), .I_AXI_ARADDR(araddr),
		.I_AXI_ARPROT(3'h0), .I_AXI_ARVALID(arv), .O_AXI_ARREADY(arready),
		.O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid),
		.I_AXI_RREADY(rready), .I_PORT_A_SEG_WAVE(seg_a), .I_PORT_B_SEG_WAVE(seg_b),
		.I_PORT_A_PIN(pin_a), .O_PORT_A_PIN(o_a), .O_PORT_A_PIN_OE(oe_a),
		.I_PORT_B_PIN(pin_b), .O_PORT_B_PIN(o_b), .O_PORT_B_PIN_OE(oe_b));
	lcd_gpio_board u_brd_a (.i_val(o_a), .i_oe(oe_a), .i_ext(ext_a), .o_pin(pin_a));
	lcd_gpio_board u_brd_b (.i_val(o_b), .i_oe(oe_b), .i_ext(ext_b), .o_pin(pin_b));
	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// sample at the falling edge: the same values the next rising edge takes
	task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
		logic aw_hit, w_hit, b_hit;
		b_hit = 1'h0;
		@(posedge clk);
		awaddr <= {14'h0, idx, 2'h0};
		wdata <= {24'h0, d};
		awv <= 1'h1;
		wv <= 1'h1;
		bready <= 1'h1;
		while (!b_hit)
		begin
			@(negedge clk);
			aw_hit = awv && awready;
			w_hit = wv && wready;
			b_hit = bvalid;
			if (b_hit)
				chk({30'h0, bresp}, {30'h0, er});
			@(posedge clk);
			if (aw_hit)
				awv <= 1'h0;
			if (w_hit)
				wv <= 1'h0;
		end
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [15:0] idx, input logic [7:0] e, input logic [1:0] er = 2'h0);
		logic ar_hit, r_hit;
		r_hit = 1'h0;
		@(posedge clk);
		araddr <= {14'h0, idx, 2'h0};
		arv <= 1'h1;
		rready <= 1'h1;
		while (!r_hit)
		begin
			@(negedge clk);
			ar_hit = arv && arready;
			r_hit = rvalid;
			if (r_hit)
			begin
				chk(rdata, {24'h0, e});
				chk({30'h0, rresp}, {30'h0, er});
			end
			@(posedge clk);
			if (ar_hit)
				arv <= 1'h0;
		end
		rready <= 1'h0;
	endtask
	// long enough for pin sync and output registers, ends off the edge
	task automatic idle();
		repeat (6) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic end_sim();
		if (n_fail == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		#500us;
		n_fail++;
		end_sim();
	end
	initial
	begin
		logic [3:0] s;
		logic [7:0] ma, mb;
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		idle();
		chk({oe_a, oe_b}, 32'h0);
		rd(`IDX_PORT_A_DIRECTION, 8'hFF);
		rd(`IDX_PORT_B_DIRECTION, 8'hFF);
		rd(`IDX_PORT_A_DATA_LATCH, 8'h5A);
		rd(`IDX_PORT_B_DATA_LATCH, 8'hC3);
		wr(`IDX_PORT_A_DIRECTION, 8'hFF);
		rd(`IDX_PORT_A_DATA_LATCH, 8'h00);
		wr(`IDX_PORT_A_DIRECTION, 8'hF0);
		wr(`IDX_PORT_A_DATA_LATCH, 8'h3C);
		wr(`IDX_PORT_B_DIRECTION, 8'h0F);
		wr(`IDX_PORT_B_DATA_LATCH, 8'h99);
		idle();
		chk({oe_a, o_a & oe_a, oe_b, o_b & oe_b}, 32'hF0300F09);
		rd(`IDX_PORT_A_DATA_LATCH, 8'h3A);
		rd(`IDX_PORT_B_DATA_LATCH, 8'hC9);
		// every select code; ends on zero so all pins return to gpio
		for (int i = 15; i >= 0; i--)
		begin
			s = 4'(i);
			ma = {{4{s[3:2] != 2'h0}}, {4{s[3:2] != 2'h0 && s != 4'h4}}};
			mb = {{4{s[3:1] != 3'h0}}, {4{s[3:1] != 3'h0 && s != 4'h2}}};
			wr(`IDX_LCD_PORT_CONTROL, {4'h0, s});
			idle();
			chk({oe_a, o_a & oe_a}, {ma | 8'hF0, (ma & seg_a) | (~ma & 8'h30)});
			chk({oe_b, o_b & oe_b}, {mb | 8'h0F, (mb & seg_b) | (~mb & 8'h09)});
			if (i == 15)
				rd(`IDX_PORT_A_DATA_LATCH, 8'h35);
		end
		wr(16'hFFD2, 8'h77, `RESP_SLVERR);
		rd(16'hFFD2, 8'h00, `RESP_SLVERR);
		// subactive runs, the three quiet modes freeze the pins
		for (int m = 1; m < 5; m++)
		begin
			wr(`IDX_POWER_MODE, 8'(m));
			wr(`IDX_PORT_A_DATA_LATCH, 8'hC3);
			wr(`IDX_PORT_B_DATA_LATCH, 8'hC6);
			idle();
			chk({oe_a, o_a & oe_a}, (m == 1) ? 32'hF0C0 : 32'hF030);
			chk({oe_b, o_b & oe_b}, (m == 1) ? 32'h0F06 : 32'h0F09);
			wr(`IDX_POWER_MODE, 8'h00);
			wr(`IDX_PORT_A_DATA_LATCH, 8'h3C);
			wr(`IDX_PORT_B_DATA_LATCH, 8'h99);
		end
		// reset again mid-run: latches and directions must return to zero
		rst <= 1'h1;
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		idle();
		chk({oe_a, oe_b}, 32'h0);
		rd(`IDX_PORT_A_DATA_LATCH, 8'h5A);
		wr(`IDX_PORT_B_DIRECTION, 8'hFF);
		rd(`IDX_PORT_B_DATA_LATCH, 8'h00);
		wr(`IDX_POWER_MODE, 8'h05);
		idle();
		chk({oe_a, oe_b}, 32'h0);
		end_sim();
	end
endmodule
